// [logic/vbm_pkg.sv]
// Purpose: shared constants and types for the broadcast mailbox unit
// Assumes: one 50 MHz clock, bus slave decode done on a simple strobe port
// Notes: no software-visible registers; configuration arrives on ports
package vbm_pkg;
	localparam logic [31:0] VBM_BCAST_BASE = 32'hFA000000;
	localparam logic [7:0]  VBM_BCAST_TOP  = 8'hFA;
	localparam int          VBM_NUM_MBOX   = 8;
	localparam int          VBM_Q_DEPTH    = 8;
	localparam int          VBM_PTR_W      = 3;
	localparam int          VBM_CNT_W      = 4;
	localparam logic [3:0]  VBM_Q_FULL     = 4'h8;
	localparam logic [2:0]  VBM_LVL_NONE   = 3'h0;
	// address bit 0 of the broadcast area selects the channel
	localparam int          VBM_CH_BIT     = 0;
	// board select field: 20 bits, one per board in the area
	localparam int          VBM_SEL_LO     = 2;
	localparam int          VBM_SEL_W      = 20;
	localparam logic [2:0]  VBM_MB_LO      = 3'h0;

	typedef struct packed {
		logic        strobe;
		logic        write;
		logic        rmw;
		logic [31:0] addr;
		logic [7:0]  wdata;
	} vbm_req_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  rdata;
	} vbm_rsp_t;

	typedef enum logic [1:0] {
		VBM_IDLE,
		VBM_RMW_HOLD
	} vbm_state_t;
endpackage

// [logic/vbm_mailbox_unit.sv]
// Purpose: broadcast channels and eight RMW mailboxes with interrupt levels
// Assumes: inputs synchronous to clk; remote and local strobes one cycle
// Notes: broadcast area also reached when the local board is master
//
// Behaviour
// - decode broadcast region at FA000000 for slave and master accesses
// - eight mailboxes, each raising its own interrupt request
// - each mailbox has programmable level and its own vector
// - mailbox accessed by indivisible read-modify-write; lock held through it
// - addressed board captures message same cycle, raises programmable IRQ
// - two broadcast channels with separate storage, sharing one write per cycle
// - channel 0 queues 8-bit messages eight deep
// - channel 1 holds exactly one 8-bit message
// - interrupt levels programmable from 1 through 7
`timescale 1ns/100ps
module vbm_mailbox_unit
	import vbm_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// remote slave access and local master access
	input  wire vbm_pkg::vbm_req_t   bus_req,
	input  wire vbm_pkg::vbm_req_t   loc_req,
	input  wire logic [4:0]          board_slot,
	output vbm_pkg::vbm_rsp_t        bus_rsp,
	// local processor side
	input  wire logic                rd_q0,
	input  wire logic                rd_q1,
	input  wire logic [7:0]          mbox_clear,
	input  wire logic                ovf_clear,
	input  wire logic [2:0]          lvl_q0,
	input  wire logic [2:0]          lvl_q1,
	input  wire logic [23:0]         lvl_mbox,
	input  wire logic [63:0]         vec_mbox,
	input  wire logic                iack,
	input  wire logic [2:0]          iack_lvl,
	output logic [7:0]               q0_data,
	output logic                     q0_valid,
	output logic [7:0]               q1_data,
	output logic                     q1_valid,
	output logic                     q0_overflow,
	output logic [7:0]               mbox_pend,
	output logic [2:0]               irq_lvl,
	output logic [7:0]               iack_vec,
	output logic                     iack_vec_valid
);
	import vbm_pkg::*;

	// broadcast hit when top byte matches and our slot bit is set
	function automatic logic bc_hit(input vbm_req_t r, input logic [4:0] s);
		logic [VBM_SEL_W-1:0] sel;
		sel = r.addr[VBM_SEL_LO +: VBM_SEL_W];
		bc_hit = r.strobe && r.write && r.addr[31:24] == VBM_BCAST_TOP
			&& r.addr[23:22] == 2'h0 && s < 5'd20 && sel[s];
	endfunction

	// level 0 means disabled; only 1..7 reach the processor
	function automatic logic [2:0] max_lvl(input logic [2:0] a,
		input logic [2:0] b);
		max_lvl = (a > b) ? a : b;
	endfunction

	logic              hit_b;
	logic              hit_l;
	logic              bc_ch0;
	logic              bc_ch1;
	logic [7:0]        bc_data;
	logic              mb_acc;
	logic [2:0]        mb_idx;

	assign hit_b   = bc_hit(bus_req, board_slot);
	assign hit_l   = bc_hit(loc_req, board_slot);
	// remote write wins the cycle; local master write is ignored then
	assign bc_data = hit_b ? bus_req.wdata : loc_req.wdata;
	assign bc_ch0  = (hit_b && !bus_req.addr[VBM_CH_BIT])
		|| (!hit_b && hit_l && !loc_req.addr[VBM_CH_BIT]);
	assign bc_ch1  = (hit_b && bus_req.addr[VBM_CH_BIT])
		|| (!hit_b && hit_l && loc_req.addr[VBM_CH_BIT]);
	// mailboxes live above the broadcast select space
	assign mb_acc  = bus_req.strobe && bus_req.rmw
		&& bus_req.addr[31:24] == VBM_BCAST_TOP
		&& bus_req.addr[23:22] == 2'h1;
	assign mb_idx  = bus_req.addr[VBM_MB_LO +: 3];

	// channel 0 queue
	logic [7:0]           q_mem [VBM_Q_DEPTH];
	logic [VBM_PTR_W-1:0] q_wr_r;
	logic [VBM_PTR_W-1:0] q_rd_r;
	logic [VBM_CNT_W-1:0] q_cnt_r;
	logic                 q_push;
	logic                 q_pop;

	assign q_pop  = rd_q0 && q_cnt_r != '0;
	assign q_push = bc_ch0 && (q_cnt_r != VBM_Q_FULL || q_pop);

	always_ff @(posedge clk) begin
		if (q_push)
			q_mem[q_wr_r] <= bc_data;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_wr_r  <= '0;
			q_rd_r  <= '0;
			q_cnt_r <= '0;
		end else begin
			if (q_push)
				q_wr_r <= q_wr_r + 3'h1;
			if (q_pop)
				q_rd_r <= q_rd_r + 3'h1;
			case ({q_push, q_pop})
				2'b10:   q_cnt_r <= q_cnt_r + 4'h1;
				2'b01:   q_cnt_r <= q_cnt_r - 4'h1;
				default: q_cnt_r <= q_cnt_r;
			endcase
		end
	end

	// overflow: set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			q0_overflow <= 1'b0;
		else if (bc_ch0 && !q_push)
			q0_overflow <= 1'b1;
		else if (ovf_clear)
			q0_overflow <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q0_data  <= 8'h00;
			q0_valid <= 1'b0;
		end else begin
			q0_valid <= (q_cnt_r != '0 && !q_pop) || q_cnt_r > 4'h1
				|| q_push;
			if (q_pop && q_cnt_r > 4'h1)
				q0_data <= q_mem[q_rd_r + 3'h1];
			else if (q_cnt_r != '0 && !q_pop)
				q0_data <= q_mem[q_rd_r];
			else if (q_push)
				q0_data <= bc_data;
		end
	end

	// channel 1 single slot, newest message replaces the old one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q1_data  <= 8'h00;
			q1_valid <= 1'b0;
		end else if (bc_ch1) begin
			q1_data  <= bc_data;
			q1_valid <= 1'b1;
		end else if (rd_q1) begin
			q1_valid <= 1'b0;
		end
	end

	// mailbox rmw lock: read half answers, write half of same cycle sets
	vbm_state_t st_r;
	logic [2:0] lk_idx_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r     <= VBM_IDLE;
			lk_idx_r <= 3'h0;
		end else begin
			case (st_r)
				VBM_IDLE:
					if (mb_acc && !bus_req.write) begin
						st_r     <= VBM_RMW_HOLD;
						lk_idx_r <= mb_idx;
					end
				VBM_RMW_HOLD:
					if (!bus_req.rmw || bus_req.write)
						st_r <= VBM_IDLE;
				default: st_r <= VBM_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			bus_rsp <= '0;
		else begin
			bus_rsp.valid <= mb_acc;
			bus_rsp.rdata <= {7'h00, mbox_pend[mb_idx]};
		end
	end

	// pending bit: remote write of the rmw sets it, local clear drops it
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			mbox_pend <= 8'h00;
		else begin
			for (int i = 0; i < VBM_NUM_MBOX; i++) begin
				if (st_r == VBM_RMW_HOLD && mb_acc && bus_req.write
					&& lk_idx_r == 3'(i))
					mbox_pend[i] <= 1'b1;
				else if (mbox_clear[i])
					mbox_pend[i] <= 1'b0;
			end
		end
	end

	// level combine and acknowledge vector
	logic [2:0] lvl_nxt;
	logic [7:0] vec_nxt;
	logic       vec_hit;

	// highest index wins a level tie on acknowledge
	always_comb begin
		lvl_nxt = VBM_LVL_NONE;
		vec_nxt = iack_vec;
		vec_hit = 1'b0;
		if (q0_valid)
			lvl_nxt = max_lvl(lvl_nxt, lvl_q0);
		if (q1_valid)
			lvl_nxt = max_lvl(lvl_nxt, lvl_q1);
		for (int i = 0; i < VBM_NUM_MBOX; i++) begin
			if (mbox_pend[i]) begin
				lvl_nxt = max_lvl(lvl_nxt, lvl_mbox[i*3 +: 3]);
				if (iack && iack_lvl == lvl_mbox[i*3 +: 3]
					&& iack_lvl != VBM_LVL_NONE) begin
					vec_nxt = vec_mbox[i*8 +: 8];
					vec_hit = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_lvl        <= VBM_LVL_NONE;
			iack_vec       <= 8'h00;
			iack_vec_valid <= 1'b0;
		end else begin
			irq_lvl        <= lvl_nxt;
			iack_vec       <= vec_nxt;
			iack_vec_valid <= vec_hit;
		end
	end
endmodule // vbm_mailbox_unit

// [verification/vbm_mailbox_unit_asserts.sv]
// Purpose: port assertions for the broadcast mailbox unit
// Assumes: one clock, reset asynchronous and active high
// Notes: bound to every instance of the unit
`timescale 1ns/100ps
module vbm_mailbox_unit_asserts
	import vbm_pkg::*;
(
	// clock, reset and remote bus
	input wire logic              clk,
	input wire logic              rst,
	input wire vbm_pkg::vbm_req_t bus_req,
	input wire logic [4:0]        board_slot,
	input wire vbm_pkg::vbm_rsp_t bus_rsp,
	// local processor side
	input wire logic              rd_q1,
	input wire logic [7:0]        mbox_clear,
	input wire logic              ovf_clear,
	input wire logic [2:0]        lvl_q1,
	input wire logic              iack,
	input wire logic              q0_valid,
	input wire logic [7:0]        q1_data,
	input wire logic              q1_valid,
	input wire logic              q0_overflow,
	input wire logic [7:0]        mbox_pend,
	input wire logic [2:0]        irq_lvl,
	input wire logic              iack_vec_valid
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	wire bc = bus_req.strobe && bus_req.write && bus_req.addr[board_slot + 5'h02]
		&& bus_req.addr[31:22] == {VBM_BCAST_TOP, 2'h0};
	wire mb = bus_req.strobe && bus_req.rmw
		&& bus_req.addr[31:22] == {VBM_BCAST_TOP, 2'h1};
	q0_capture_a: assert property (bc && !bus_req.addr[0]
		|=> ##[0:1] q0_valid) else $error("channel 0 message lost");
	q1_capture_a: assert property (bc && bus_req.addr[0] && !rd_q1
		|=> q1_valid && q1_data == $past(bus_req.wdata))
		else $error("channel 1 message lost");
	mbox_answer_a: assert property (mb |=> bus_rsp.valid)
		else $error("mailbox strobe not answered");
	ovf_sticky_a: assert property (q0_overflow && !ovf_clear
		|=> q0_overflow) else $error("overflow flag dropped");
	slot_hold_a: assert property (q1_valid && !rd_q1 |=> q1_valid)
		else $error("channel 1 message vanished");
	pend_hold_a: assert property (1'b1 |=>
		($past(mbox_pend) & ~$past(mbox_clear) & ~mbox_pend) == 8'h00)
		else $error("mailbox pending lost without clear");
	irq_level_a: assert property (q1_valid |=> irq_lvl >= $past(lvl_q1))
		else $error("interrupt level below channel 1 level");
	vec_cause_a: assert property (iack_vec_valid |-> $past(iack))
		else $error("vector without acknowledge");
endmodule // vbm_mailbox_unit_asserts
bind vbm_mailbox_unit vbm_mailbox_unit_asserts u_vbm_mailbox_unit_asserts(
	.clk, .rst, .bus_req, .board_slot, .bus_rsp, .rd_q1, .mbox_clear,
	.ovf_clear, .lvl_q1, .iack, .q0_valid, .q1_data, .q1_valid,
	.q0_overflow, .mbox_pend, .irq_lvl, .iack_vec_valid);

// [verification/vbm_remote_master.sv]
// Purpose: remote bus master driving the unit's slave port
// Assumes: tasks are entered at a falling edge
// Notes: released lines carry the inverted address, with inverted data in bcast and FF data in rmw
`timescale 1ns/100ps
module vbm_remote_master
	import vbm_pkg::*;
(
	input wire logic              clk,
	output vbm_pkg::vbm_req_t     req,
	input wire vbm_pkg::vbm_rsp_t rsp
);
	initial req = '0;
	// one plain write; the address picks the boards
	task automatic bcast(input logic [31:0] a, input logic [7:0] d);
		req = '{1'b1, 1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '{1'b0, 1'b0, 1'b0, ~a, ~d};
		@(negedge clk);
	endtask
	// rmw held through both phases so the lock is kept
	task automatic rmw(input logic [2:0] ix, output logic [7:0] rd);
		logic [31:0] a;
		// the unit takes the mailbox index from the low address bits
		a = 32'hFA400000 | {29'h0, ix};
		req = '{1'b1, 1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		rd = rsp.rdata;
		req.strobe = 1'b0;
		@(negedge clk);
		req = '{1'b1, 1'b1, 1'b1, a, rd | 8'h01};
		@(negedge clk);
		req = '{1'b0, 1'b0, 1'b0, ~a, 8'hFF};
		@(negedge clk);
	endtask
endmodule // vbm_remote_master

// [verification/vbm_mailbox_unit_tb.sv]
// Purpose: self-checking bench for the broadcast mailbox unit
// Assumes: board slot 5; inputs change on the falling edge
// Notes: levels and vectors fixed for the whole run
`timescale 1ns/100ps
module vbm_mailbox_unit_tb;
	import vbm_pkg::*;
	logic       clk, rst, rd_q0, rd_q1, ovf_clear, iack, q0_valid, q1_valid;
	logic       q0_overflow, iack_vec_valid;
	logic [7:0] mbox_clear, q0_data, q1_data, mbox_pend, iack_vec, d;
	logic [2:0] iack_lvl, irq_lvl;
	vbm_req_t   bus_req, loc_req;
	vbm_rsp_t   bus_rsp;
	int         fails, n_compared;
	localparam logic [31:0] A0 = 32'hFA000080;
	vbm_remote_master u_vbm_remote_master(.clk, .req(bus_req), .rsp(bus_rsp));
	vbm_mailbox_unit u_vbm_mailbox_unit(.clk, .rst, .bus_req, .loc_req,
		.board_slot(5'h05), .bus_rsp, .rd_q0, .rd_q1, .mbox_clear,
		.ovf_clear, .lvl_q0(3'h3), .lvl_q1(3'h6),
		.lvl_mbox({3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h7}),
		.vec_mbox(64'hA7A6A5A4A3A2A1A0), .iack, .iack_lvl, .q0_data,
		.q0_valid, .q1_data, .q1_valid, .q0_overflow, .mbox_pend,
		.irq_lvl, .iack_vec, .iack_vec_valid);
	task automatic chk(input logic [63:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic stop_test;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_queue;
		for (int i = 0; i < 9; i++)
			u_vbm_remote_master.bcast(A0, 8'h10 + 8'(i));
		w(1);
		chk(q0_overflow, 1'b1);
		chk(irq_lvl, 3'h3);
		for (int i = 0; i < 8; i++) begin
			chk(q0_data, 8'h10 + 8'(i));
			pulse(rd_q0);
			w(1);
		end
		chk(q0_valid, 1'b0);
		pulse(ovf_clear);
		w(1);
		chk(q0_overflow, 1'b0);
	endtask
	task automatic t_single;
		u_vbm_remote_master.bcast(A0 | 32'h1, 8'h5A);
		u_vbm_remote_master.bcast(A0 | 32'h1, 8'hC3);
		u_vbm_remote_master.bcast(32'hFA000101, 8'h11);
		u_vbm_remote_master.bcast(32'hFB000081, 8'h22);
		chk(q1_data, 8'hC3);
		chk(q0_valid, 1'b0);
		chk(irq_lvl, 3'h6);
		pulse(rd_q1);
		w(1);
		chk(q1_valid, 1'b0);
		loc_req = '{1'b1, 1'b1, 1'b0, A0, 8'h77};
		w(1);
		loc_req = '{1'b0, 1'b0, 1'b0, ~A0, 8'h88};
		w(1);
		chk(q0_data, 8'h77);
		pulse(rd_q0);
		w(1);
	endtask
	task automatic t_mbox;
		logic [2:0] lv;
		for (int i = 0; i < 8; i++) begin
			lv = (i == 0) ? 3'h7 : 3'(i);
			u_vbm_remote_master.rmw(i[2:0], d);
			chk(d[0], 1'b0);
			w(1);
			chk(mbox_pend, 8'h01 << i);
			chk(irq_lvl, lv);
			u_vbm_remote_master.rmw(i[2:0], d);
			chk(d[0], 1'b1);
			iack_lvl = lv;
			pulse(iack);
			chk(iack_vec_valid, 1'b1);
			chk(iack_vec, 8'hA0 + 8'(i));
			mbox_clear = 8'h01 << i;
			w(1);
			mbox_clear = 8'h00;
			w(1);
			chk(mbox_pend, 8'h00);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{rst, rd_q0, rd_q1, ovf_clear, iack} = 5'h10;
		{mbox_clear, iack_lvl, loc_req} = '0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		w(1);
		t_queue;
		t_single;
		t_mbox;
		stop_test;
	end
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		stop_test;
	end
endmodule // vbm_mailbox_unit_tb
